// ### bench/pmq_partner.sv
// Purpose: writer and reader model on the far side of both data ports
// Assumes: one clock serves both ports; queue change takes three cycles
// Notes: idle write data is the inverse of the filler word, so stale data shows
`timescale 1ns/1ps
module pmq_partner #(
  parameter logic [2:0] DEV_ID = 3'b101
) (
  // clock
  input wire logic clk_i,
  // write side
  output logic write_en_n_o,
  output pmq_pkg::pmq_word_type write_word_o,
  output logic write_queue_select_strobe_o,
  output logic [4:0] write_queue_address_bus_o,
  // read side
  output logic read_en_n_o,
  output logic output_enable_n_o,
  output logic read_queue_select_strobe_o,
  output logic empty_flag_bus_strobe_o,
  output logic null_queue_select_o,
  output logic [4:0] read_queue_address_bus_o
);
  // quiet ports at time zero
  initial begin
    write_en_n_o = 1'b1;
    write_word_o = '0;
    write_queue_select_strobe_o = 1'b0;
    write_queue_address_bus_o = {DEV_ID, 2'b00};
    read_en_n_o = 1'b1;
    output_enable_n_o = 1'b1;
    read_queue_select_strobe_o = 1'b0;
    empty_flag_bus_strobe_o = 1'b0;
    null_queue_select_o = 1'b0;
    read_queue_address_bus_o = {DEV_ID, 2'b00};
  end

  // one write cycle, launched just after an edge
  task automatic wcyc(input logic en_n, input pmq_pkg::pmq_word_type w, input logic s,
                      input logic [1:0] q);
    @(posedge clk_i);
    write_en_n_o <= en_n;
    write_word_o <= w;
    write_queue_select_strobe_o <= s;
    write_queue_address_bus_o <= {DEV_ID, q};
  endtask

  // whole packet first, change asked on its end word, then the filler
  task automatic send(input pmq_pkg::pmq_word_type w[$], input logic chg,
                      input logic [1:0] nq, input pmq_pkg::pmq_word_type fill);
    if (chg && w.size() == 0) begin
      wcyc(1'b1, ~fill, 1'b1, nq);
    end
    for (int i = 0; i < w.size(); i++) begin
      wcyc(1'b0, w[i], chg && i == w.size() - 1, nq);
    end
    if (chg) begin
      wcyc(1'b1, ~fill, 1'b0, nq);
      wcyc(1'b0, {2'b00, fill.payload}, 1'b0, nq);
    end
    wcyc(1'b1, ~fill, 1'b0, nq);
  endtask

  // read queue change; callers switch only once the end word is out
  task automatic rsel(input logic nul, input logic [1:0] q);
    @(posedge clk_i);
    read_queue_select_strobe_o <= 1'b1;
    null_queue_select_o <= nul;
    read_queue_address_bus_o <= {DEV_ID, q};
    @(posedge clk_i);
    read_queue_select_strobe_o <= 1'b0;
    null_queue_select_o <= 1'b0;
  endtask

  // flag bus device select with a given identity
  task automatic fsel(input logic [2:0] id);
    @(posedge clk_i);
    empty_flag_bus_strobe_o <= 1'b1;
    read_queue_address_bus_o <= {id, 2'b00};
    @(posedge clk_i);
    empty_flag_bus_strobe_o <= 1'b0;
  endtask

  // read enable and output drive move together
  task automatic rden(input logic en_n);
    @(posedge clk_i);
    read_en_n_o <= en_n;
    output_enable_n_o <= en_n;
  endtask
endmodule

// ### bench/pmq_top_tb.sv
// Purpose: self-checking bench for the packet mode queue switch
// Assumes: packet mode with direct bus first, then a reset into standard mode, polled bus
// Notes: every delivered word is captured at the edge ending its valid cycle
`timescale 1ns/1ps
`include "pmq_params.svh"
module pmq_top_tb;
  localparam int DEPTH = 8;
  localparam logic [2:0] DEV_ID = 3'b101;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_req = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [3:0] wb_sel = 4'hF;
  // straps, changed only while reset is held
  logic pkt_sel = 1'b1;
  logic fm = 1'b0;
  logic wen_n, wstb, ren_n, oe_n, rstb, fstr, nsel, full_n, ov_n, pr_n, ae_oe;
  logic [4:0] wadr, radr;
  logic [3:0] ae_bus;
  pmq_pkg::pmq_word_type wword, rword;
  pmq_pkg::pmq_word_type pk[$], rx_q[$], exp_q[$];
  int seed = 54;
  int fail_count = 0;
  int total_checks = 0;

  // clock and design
  always #10 clk = ~clk;
  pmq_top #(.DEPTH(DEPTH)) dut_u (.clk_i(clk), .rst_i(rst), .packet_mode_select_i(pkt_sel),
    .flag_bus_style_i(fm), .device_identity_inputs_i(DEV_ID), .write_en_n_i(wen_n),
    .write_word_i(wword), .write_queue_select_strobe_i(wstb),
    .write_queue_address_bus_i(wadr), .full_flag_n_o(full_n), .read_en_n_i(ren_n),
    .output_enable_n_i(oe_n), .read_queue_select_strobe_i(rstb),
    .empty_flag_bus_strobe_i(fstr), .null_queue_select_i(nsel),
    .read_queue_address_bus_i(radr), .read_word_o(rword), .output_valid_n_o(ov_n),
    .packet_ready_n_o(pr_n), .almost_empty_bus_o(ae_bus), .almost_empty_bus_oe_o(ae_oe),
    .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  pmq_partner #(.DEV_ID(DEV_ID)) pk_u (.clk_i(clk), .write_en_n_o(wen_n),
    .write_word_o(wword), .write_queue_select_strobe_o(wstb),
    .write_queue_address_bus_o(wadr), .read_en_n_o(ren_n), .output_enable_n_o(oe_n),
    .read_queue_select_strobe_o(rstb), .empty_flag_bus_strobe_o(fstr),
    .null_queue_select_o(nsel), .read_queue_address_bus_o(radr));

  // capture words while valid is low
  always @(posedge clk) begin
    if (rst === 1'b0 && ov_n === 1'b0) rx_q.push_back(rword);
  end

  // random payload, markers chosen by the caller
  function automatic pmq_pkg::pmq_word_type rw(input logic s, input logic e);
    rw.end_mark = e;
    rw.start_mark = s;
    rw.payload = 34'({$random(seed), $random(seed)});
  endfunction

  // packet of n words, start on the first, end on the last
  task automatic mk(input int n);
    pk.delete();
    for (int i = 0; i < n; i++) pk.push_back(rw(i == 0, i == n - 1));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // classic single wishbone cycle, waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    wb_req <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("MISMATCH t=%0t no ack on the register bus", $time);
    end
    @(posedge clk);
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic cmp_w(input logic [35:0] got, input logic [35:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_rx(input string what);
    cmp_w(36'(rx_q.size()), 36'(exp_q.size()), what);
    foreach (exp_q[i]) begin
      if (i < rx_q.size()) cmp_w(rx_q[i], exp_q[i], what);
    end
    rx_q.delete();
    exp_q.delete();
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, well past the planned run
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    pmq_pkg::pmq_word_type f0, f1, f2, f3;
    logic [31:0] rd;
    int n;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    cmp_bit(full_n, 1'b1, "full after reset");
    cmp_bit(pr_n, 1'b1, "ready after reset");
    wb(1'b0, `PMQ_STATUS_OFFSET, 32'h0, rd);
    cmp_w(36'(rd), 36'(32'h1 << `PMQ_ST_PKT_BIT), "status");
    wb(1'b0, 8'h08, 32'h0, rd);
    cmp_w(36'(rd), 36'h0, "unmapped read");
    wb(1'b1, `PMQ_CTRL_OFFSET, 32'h0000_0001, rd);
    wb(1'b0, `PMQ_CTRL_OFFSET, 32'h0, rd);
    cmp_w(36'(rd), 36'h1, "hold readback");
    mk(2);
    pk_u.send(pk, 1'b0, 2'd0, pk[0]);
    wb(1'b1, `PMQ_CTRL_OFFSET, 32'h0, rd);
    // write with byte lane 0 off must leave the control byte alone
    wb_sel <= 4'hE;
    wb(1'b1, `PMQ_CTRL_OFFSET, 32'h0000_0001, rd);
    wb_sel <= 4'hF;
    wb(1'b0, `PMQ_CTRL_OFFSET, 32'h0, rd);
    cmp_w(36'(rd), 36'h0, "sel lane off");
    $display("test reset done");
    // partial packet with a repeated start must not leave
    pk_u.rden(1'b0);
    pk = {rw(1'b1, 1'b0), rw(1'b1, 1'b0), rw(1'b0, 1'b0), rw(1'b0, 1'b0)};
    exp_q = pk;
    pk_u.send(pk, 1'b0, 2'd0, pk[0]);
    tick(10);
    cmp_bit(rx_q.size() == 0, 1'b1, "early delivery");
    cmp_bit(pr_n, 1'b1, "ready on partial");
    pk_u.rden(1'b1);
    pk = {rw(1'b0, 1'b0), rw(1'b0, 1'b1)};
    exp_q = {exp_q, pk};
    f0 = rw(1'b0, 1'b0);
    pk_u.send(pk, 1'b1, 2'd1, f0);
    tick(3);
    cmp_bit(pr_n, 1'b0, "ready on whole");
    cmp_bit(ae_bus[0], 1'b0, "bus queue 0");
    pk_u.rden(1'b0);
    tick(20);
    cmp_rx("packet q0");
    cmp_bit(pr_n, 1'b1, "ready drained");
    $display("test packet done");
    // read change: old filler then the new queue packet
    mk(4);
    f1 = rw(1'b0, 1'b0);
    pk_u.send(pk, 1'b1, 2'd2, f1);
    tick(3);
    cmp_bit(pr_n, 1'b1, "discrete on q0");
    cmp_bit(ae_bus[1], 1'b0, "bus queue 1");
    exp_q = {f0, pk};
    pk_u.rsel(1'b0, 2'd1);
    tick(20);
    cmp_rx("change to q1");
    $display("test change done");
    // fill q2, drop the extra word, full flag follows the new queue
    mk(DEPTH);
    exp_q = {f1, pk};
    pk_u.send(pk, 1'b0, 2'd2, pk[0]);
    tick(2);
    cmp_bit(full_n, 1'b0, "full q2");
    f2 = rw(1'b0, 1'b0);
    fork
      pk_u.send({rw(1'b1, 1'b1)}, 1'b1, 2'd3, f2);
      begin
        tick(2);
        cmp_bit(full_n, 1'b0, "full before swap");
        tick(2);
        cmp_bit(full_n, 1'b1, "full after swap");
      end
    join
    pk_u.rsel(1'b0, 2'd2);
    tick(25);
    cmp_rx("full q2");
    $display("test full done");
    // null queue ignores the address and never delivers
    mk(4);
    f3 = rw(1'b0, 1'b0);
    pk_u.send(pk, 1'b1, 2'd0, f3);
    pk_u.rsel(1'b1, 2'd3);
    tick(15);
    cmp_bit(rx_q.size() == 0, 1'b1, "null delivery");
    exp_q = pk;
    pk_u.rsel(1'b0, 2'd3);
    tick(15);
    cmp_rx("from null to q3");
    $display("test null done");
    // flag bus device select by identity
    pk_u.fsel(3'b010);
    tick(3);
    cmp_bit(ae_oe, 1'b0, "flag select other");
    pk_u.fsel(DEV_ID);
    tick(3);
    cmp_bit(ae_oe, 1'b1, "flag select own");
    $display("test flag bus done");
    // second reset: standard mode, polled bus, unmarked words drain
    pk_u.rden(1'b1);
    pkt_sel <= 1'b0;
    fm <= 1'b1;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    wb(1'b0, `PMQ_STATUS_OFFSET, 32'h0, rd);
    cmp_w(36'(rd), 36'h0, "status std");
    f0 = rw(1'b0, 1'b0);
    pk_u.send({f0}, 1'b0, 2'd0, f0);
    tick(2);
    cmp_bit(pr_n, 1'b1, "ready std");
    // polled style shows queue 0 once in four cycles
    n = 0;
    repeat (4) begin
      tick(1);
      n += (ae_bus[0] === 1'b0);
    end
    cmp_w(36'(n), 36'h1, "polled bus");
    exp_q = {f0};
    pk_u.rden(1'b0);
    tick(4);
    cmp_rx("std drain");
    $display("test standard done");
    give_verdict();
  end
endmodule

// ### hdl/pmq_flag_bus.sv
// Purpose: per-queue status bus, direct or polled style
// Assumes: status inputs are active high, bus is active low
// Notes: style is caught during master reset
`timescale 1ns/1ps
`include "pmq_params.svh"
module pmq_flag_bus #(
  parameter int QUEUES = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flag_bus_style_i,
  // device select
  input wire logic select_i,
  input wire logic [2:0] select_id_i,
  input wire logic [2:0] device_identity_inputs_i,
  // status in, bus out
  input wire logic [QUEUES-1:0] status_i,
  output logic [QUEUES-1:0] bus_o,
  output logic bus_oe_o
);
  localparam int QW = $clog2(QUEUES);
  logic polled, next_polled, chosen, next_chosen;
  logic [QW-1:0] poll, next_poll;
  logic [QUEUES-1:0] next_bus;

  // selection, poll pointer and bus value
  always_comb begin
    next_polled = polled;
    next_chosen = chosen;
    if (rst_i) begin
      next_polled = flag_bus_style_i;
    end
    if (select_i) begin
      next_chosen = (select_id_i == device_identity_inputs_i);
    end
    next_poll = poll + 1'b1;
    next_bus = ~status_i;
    if (polled) begin
      // polled style shows one queue at a time, rest inactive
      next_bus = {QUEUES{1'b1}};
      next_bus[poll] = ~status_i[poll];
    end
  end

  // register the bus so it never glitches between queues
  always_ff @(posedge clk_i) begin
    polled <= next_polled;
    if (rst_i) begin
      chosen <= 1'b1;
      poll <= '0;
      bus_o <= {QUEUES{1'b1}};
      bus_oe_o <= 1'b0;
    end else begin
      chosen <= next_chosen;
      poll <= next_poll;
      bus_o <= next_bus;
      bus_oe_o <= next_chosen;
    end
  end
endmodule

// ### hdl/pmq_params.svh
// Purpose: constants of the packet mode queue switch block
// Assumes: 50 MHz clock, four queues, 36-bit words
// Notes: offsets are byte addresses on the register bus
`ifndef PMQ_PARAMS_SVH
`define PMQ_PARAMS_SVH
// register offsets
`define PMQ_CTRL_OFFSET 8'h00
`define PMQ_STATUS_OFFSET 8'h04
// control fields
`define PMQ_CTRL_HOLD_BIT 0
`define PMQ_CTRL_RESET 32'h0000_0000
// status fields
`define PMQ_ST_READY_LSB 0
`define PMQ_ST_WQ_LSB 4
`define PMQ_ST_RQ_LSB 6
`define PMQ_ST_NULL_BIT 8
`define PMQ_ST_PKT_BIT 9
// queue change timing, in cycles of the port clock
`define PMQ_CHANGE_CYCLES 3
// marker bit positions of a word
`define PMQ_START_BIT 34
`define PMQ_END_BIT 35
`endif

// ### hdl/pmq_pkg.sv
// Purpose: types of the packet mode queue switch block
// Assumes: 36-bit word, markers on the two top bits
// Notes: constants live in pmq_params.svh
package pmq_pkg;
  // one stored word: end marker, start marker, payload
  typedef struct packed {
    logic end_mark;
    logic start_mark;
    logic [33:0] payload;
  } pmq_word_type;
  // queue change progress on either port
  typedef enum logic [1:0] {
    PMQ_IDLE = 2'b00,
    PMQ_REQ = 2'b01,
    PMQ_SWAP = 2'b10
  } pmq_phase_type;
endpackage

// ### hdl/pmq_queue.sv
// Purpose: one queue: word storage plus packet counter
// Assumes: DEPTH is a power of two
// Notes: head word is presented combinationally
`timescale 1ns/1ps
`include "pmq_params.svh"
module pmq_queue #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic push_i,
  input wire pmq_pkg::pmq_word_type push_word_i,
  // drain side
  input wire logic pop_i,
  output pmq_pkg::pmq_word_type head_o,
  // status
  output logic empty_o,
  output logic full_o,
  output logic readable_o
);
  localparam int AW = $clog2(DEPTH);
  pmq_pkg::pmq_word_type mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] fill, next_fill, pkts, next_pkts;
  logic w_in, r_in, next_w_in, next_r_in;
  logic push_ok, pop_ok, pkt_done, pkt_gone;

  // storage, addressed by the write pointer
  always_ff @(posedge clk_i) begin
    if (push_ok) begin
      mem[wr_ptr] <= push_word_i;
    end
  end

  // next pointers, fill level and packet trackers
  always_comb begin
    push_ok = push_i && !full_o;
    pop_ok = pop_i && !empty_o;
    // repeated start ignored; an end closes only an open packet
    pkt_done = push_ok && push_word_i.end_mark && (w_in || push_word_i.start_mark);
    pkt_gone = pop_ok && head_o.end_mark && (r_in || head_o.start_mark);
    next_w_in = w_in;
    if (push_ok && push_word_i.start_mark) begin
      next_w_in = 1'b1;
    end
    if (push_ok && push_word_i.end_mark) begin
      next_w_in = 1'b0;
    end
    next_r_in = r_in;
    if (pop_ok && head_o.start_mark) begin
      next_r_in = 1'b1;
    end
    if (pop_ok && head_o.end_mark) begin
      next_r_in = 1'b0;
    end
    next_wr_ptr = push_ok ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop_ok ? rd_ptr + 1'b1 : rd_ptr;
    next_fill = fill + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
    next_pkts = pkts + (AW+1)'(pkt_done) - (AW+1)'(pkt_gone);
  end

  // register the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
      pkts <= '0;
      w_in <= 1'b0;
      r_in <= 1'b0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
      pkts <= next_pkts;
      w_in <= next_w_in;
      r_in <= next_r_in;
    end
  end

  // status seen by both ports
  always_comb begin
    head_o = mem[rd_ptr];
    empty_o = (fill == '0);
    full_o = (fill == (AW+1)'(DEPTH));
    // a packet in flight may be drained to its end
    readable_o = !empty_o && (pkts != '0 || r_in);
  end

  a_full_no_store: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i && full_o |=> fill == $past(fill) - (AW+1)'($past(pop_ok)))
    else $error("write stored into a full queue");
  a_pkt_count_up: assert property (@(posedge clk_i) disable iff (rst_i)
    pkt_done && !pkt_gone |=> pkts == $past(pkts) + 1'b1)
    else $error("packet counter missed a finished packet");
endmodule

// ### hdl/pmq_top.sv
// Purpose: four-queue packet switch with queue select on both ports
// Assumes: one clock serves write and read port; Wishbone register slave
// Notes: output_valid_n marks the cycle a delivered word is on read_word_o
// Behaviour
// - read select strobe latches low read address bits to pick a queue.
// - write select strobe plus address requests change; takes three cycles.
// - request cycle and next still write the old queue.
// - full flag shows the new queue from the third cycle's edge.
// - fourth cycle onward writes go to new queue; full queue blocks writes.
// - request cycle and next still read old queue when strobes allow.
// - filler of old queue then first word of new; reader drops filler.
// - packet mode is caught from its select input during reset.
// - packet state per queue; discrete flag follows read queue only.
// - packet ready low only with a complete packet held.
// - packet mode delivers nothing but the change filler before a whole packet is stored.
// - status bus carries packet ready, or not-empty in standard mode; style caught at reset.
// - start and end markers ride on the top two word bits.
// - per-queue packet counter follows markers in and out.
// - null select switches read port to an always-empty queue.
// - repeated start or end markers are ignored.
`timescale 1ns/1ps
`include "pmq_params.svh"
module pmq_top #(
  parameter int DEPTH = 16
) (
  // clock and master reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic packet_mode_select_i,
  input wire logic flag_bus_style_i,
  input wire logic [2:0] device_identity_inputs_i,
  // write port
  input wire logic write_en_n_i,
  input wire pmq_pkg::pmq_word_type write_word_i,
  input wire logic write_queue_select_strobe_i,
  input wire logic [4:0] write_queue_address_bus_i,
  output logic full_flag_n_o,
  // read port
  input wire logic read_en_n_i,
  input wire logic output_enable_n_i,
  input wire logic read_queue_select_strobe_i,
  input wire logic empty_flag_bus_strobe_i,
  input wire logic null_queue_select_i,
  input wire logic [4:0] read_queue_address_bus_i,
  output pmq_pkg::pmq_word_type read_word_o,
  output logic output_valid_n_o,
  output logic packet_ready_n_o,
  output logic [3:0] almost_empty_bus_o,
  output logic almost_empty_bus_oe_o,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  localparam int Q = 4;
  logic pkt_mode, next_pkt_mode;
  logic [31:0] ctrl, next_ctrl, next_wb_dat;
  logic next_wb_ack;
  // per-queue wires
  logic [Q-1:0] push, pop, empty, full, readable, avail;
  pmq_pkg::pmq_word_type head [Q];
  // write port state
  pmq_pkg::pmq_phase_type w_phase, next_w_phase;
  logic [1:0] wq, w_new, next_wq, next_w_new;
  logic next_full_n;
  // read port state
  pmq_pkg::pmq_phase_type r_phase, next_r_phase;
  logic [1:0] rq, r_new, next_rq, next_r_new;
  logic r_null, r_new_null, next_r_null, next_r_new_null;
  logic [1:0] pop_q;
  logic pop_any;
  pmq_pkg::pmq_word_type next_read_word;
  logic next_valid_n, next_ready_n;

  // the queues themselves
  for (genvar g = 0; g < Q; g++) begin : g_queue
    pmq_queue #(
      .DEPTH(DEPTH)
    ) u_queue (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(push[g]),
      .push_word_i(write_word_i),
      .pop_i(pop[g]),
      .head_o(head[g]),
      .empty_o(empty[g]),
      .full_o(full[g]),
      .readable_o(readable[g])
    );
    // standard mode drains any stored word
    assign avail[g] = pkt_mode ? readable[g] : !empty[g];
  end

  // write port: queue change sequence and routing
  always_comb begin
    next_w_phase = w_phase;
    next_wq = wq;
    next_w_new = w_new;
    next_full_n = !full[wq];
    push = '0;
    // old queue until the swap edge, strobe high writes nothing
    if (!write_en_n_i && !ctrl[`PMQ_CTRL_HOLD_BIT]) begin
      push[wq] = 1'b1;
    end
    case (w_phase)
      pmq_pkg::PMQ_IDLE: begin
        if (write_queue_select_strobe_i) begin
          next_w_new = write_queue_address_bus_i[1:0];
          next_w_phase = pmq_pkg::PMQ_REQ;
        end
      end
      pmq_pkg::PMQ_REQ: begin
        next_w_phase = pmq_pkg::PMQ_SWAP;
      end
      pmq_pkg::PMQ_SWAP: begin
        // flag turns to the new queue on the filler cycle edge
        next_full_n = !full[w_new];
        next_wq = w_new;
        next_w_phase = pmq_pkg::PMQ_IDLE;
      end
      default: begin
        next_w_phase = pmq_pkg::PMQ_IDLE;
      end
    endcase
  end

  // read port: queue change, filler pass and delivery
  always_comb begin
    next_r_phase = r_phase;
    next_rq = rq;
    next_r_null = r_null;
    next_r_new = r_new;
    next_r_new_null = r_new_null;
    pop_q = rq;
    pop_any = !read_en_n_i && !output_enable_n_i && !r_null && avail[rq];
    case (r_phase)
      pmq_pkg::PMQ_IDLE: begin
        if (read_queue_select_strobe_i && !empty_flag_bus_strobe_i) begin
          next_r_new = read_queue_address_bus_i[1:0];
          next_r_new_null = null_queue_select_i;
          next_r_phase = pmq_pkg::PMQ_REQ;
        end
      end
      pmq_pkg::PMQ_REQ: begin
        next_r_phase = pmq_pkg::PMQ_SWAP;
      end
      pmq_pkg::PMQ_SWAP: begin
        // filler word leaves the old queue whatever the strobe
        pop_any = !r_null && !empty[rq];
        next_rq = r_new;
        next_r_null = r_new_null;
        next_r_phase = pmq_pkg::PMQ_IDLE;
      end
      default: begin
        next_r_phase = pmq_pkg::PMQ_IDLE;
      end
    endcase
    pop = '0;
    pop[pop_q] = pop_any;
    next_read_word = pop_any ? head[pop_q] : read_word_o;
    next_valid_n = !pop_any;
    // discrete flag follows only the queue on the read port
    next_ready_n = !(pkt_mode && !next_r_null && readable[next_rq]);
  end

  // port state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w_phase <= pmq_pkg::PMQ_IDLE;
      wq <= 2'h0;
      w_new <= 2'h0;
      full_flag_n_o <= 1'b1;
      r_phase <= pmq_pkg::PMQ_IDLE;
      rq <= 2'h0;
      r_new <= 2'h0;
      r_null <= 1'b0;
      r_new_null <= 1'b0;
      read_word_o <= '0;
      output_valid_n_o <= 1'b1;
      packet_ready_n_o <= 1'b1;
    end else begin
      w_phase <= next_w_phase;
      wq <= next_wq;
      w_new <= next_w_new;
      full_flag_n_o <= next_full_n;
      r_phase <= next_r_phase;
      rq <= next_rq;
      r_new <= next_r_new;
      r_null <= next_r_null;
      r_new_null <= next_r_new_null;
      read_word_o <= next_read_word;
      output_valid_n_o <= next_valid_n;
      packet_ready_n_o <= next_ready_n;
    end
  end

  // mode strap caught while reset is held
  always_comb begin
    next_pkt_mode = rst_i ? packet_mode_select_i : pkt_mode;
  end

  always_ff @(posedge clk_i) begin
    pkt_mode <= next_pkt_mode;
  end

  // status bus: packet ready per queue, or not-empty in standard mode
  pmq_flag_bus #(
    .QUEUES(Q)
  ) u_flag_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flag_bus_style_i(flag_bus_style_i),
    .select_i(!read_queue_select_strobe_i && empty_flag_bus_strobe_i),
    .select_id_i(read_queue_address_bus_i[4:2]),
    .device_identity_inputs_i(device_identity_inputs_i),
    .status_i(avail),
    .bus_o(almost_empty_bus_o),
    .bus_oe_o(almost_empty_bus_oe_o)
  );

  // wishbone: one wait state, unmapped reads give zero
  always_comb begin
    next_ctrl = ctrl;
    next_wb_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_wb_dat = 32'h0000_0000;
    if (next_wb_ack && wb_we_i && wb_sel_i[0] && wb_adr_i == `PMQ_CTRL_OFFSET) begin
      next_ctrl = {24'h00_0000, wb_dat_i[7:0]};
    end
    if (wb_adr_i == `PMQ_CTRL_OFFSET) begin
      next_wb_dat = ctrl;
    end
    if (wb_adr_i == `PMQ_STATUS_OFFSET) begin
      next_wb_dat[`PMQ_ST_READY_LSB +: 4] = avail;
      next_wb_dat[`PMQ_ST_WQ_LSB +: 2] = wq;
      next_wb_dat[`PMQ_ST_RQ_LSB +: 2] = rq;
      next_wb_dat[`PMQ_ST_NULL_BIT] = r_null;
      next_wb_dat[`PMQ_ST_PKT_BIT] = pkt_mode;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `PMQ_CTRL_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      wb_ack_o <= next_wb_ack;
      wb_dat_o <= next_wb_dat;
    end
  end

  // checks
  a_wq_three_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
    w_phase == pmq_pkg::PMQ_IDLE && write_queue_select_strobe_i
    |-> ##1 wq == $past(wq) ##1 wq == $past(wq, 2)
    ##1 wq == $past(write_queue_address_bus_i[1:0], 3))
    else $error("write queue change not taken on third cycle");
  a_full_new_queue: assert property (@(posedge clk_i) disable iff (rst_i)
    w_phase == pmq_pkg::PMQ_SWAP |=> full_flag_n_o == !$past(full[w_new]))
    else $error("full flag did not follow new queue");
  a_no_write_high: assert property (@(posedge clk_i) disable iff (rst_i)
    write_en_n_i |-> push == '0)
    else $error("write taken with strobe high");
  a_rd_select_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    r_phase == pmq_pkg::PMQ_IDLE && read_queue_select_strobe_i
    && !empty_flag_bus_strobe_i && !null_queue_select_i
    |-> ##3 rq == $past(read_queue_address_bus_i[1:0], 3) && !r_null)
    else $error("read queue not latched from address");
  a_no_early_read: assert property (@(posedge clk_i) disable iff (rst_i)
    pkt_mode && r_phase != pmq_pkg::PMQ_SWAP && !readable[pop_q] |-> !pop_any)
    else $error("word delivered before a whole packet");
  a_null_no_read: assert property (@(posedge clk_i) disable iff (rst_i)
    r_null && r_phase == pmq_pkg::PMQ_IDLE |=> output_valid_n_o)
    else $error("null queue delivered a word");
  a_ready_tracks: assert property (@(posedge clk_i) disable iff (rst_i)
    pkt_mode && !r_null && r_phase == pmq_pkg::PMQ_IDLE
    |=> packet_ready_n_o == !$past(readable[rq]))
    else $error("packet ready flag not from read queue");
  a_mode_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !rst_i |=> $stable(pkt_mode))
    else $error("packet mode changed outside reset");
endmodule
